// ### core/cal_tag_bank.sv
// Colour calibration tag bank: three two-channel trim sets with checksum
// tags, priority selection and per-channel current gain output.
// Assumes a single 20 MHz clock, a synchronous active-low reset and a
// register master that never issues read and write together.
`timescale 1ns/1ns
`include "cal_tag_consts.svh"

module cal_tag_bank (
	input  wire logic                    sys_clk,
	input  wire logic                    rst_n,
	input  wire cal_tag_pkg::reg_req_t   req,
	output logic                   [7:0] rdata,
	output cal_tag_pkg::gain_pair_t      gain,
	output cal_tag_pkg::cal_sel_t        active_set,
	output logic                         tag_mismatch
);
	import cal_tag_pkg::*;

	// ------------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------------
	cal_set_t    set_a_r;
	cal_set_t    set_b_r;
	cal_set_t    set_c_r;
	logic  [7:0] rdata_r;
	gain_pair_t  gain_r;
	cal_sel_t    sel_r;
	logic        mismatch_r;

	logic        wr_a_ch1;
	logic        wr_a_ch2;
	logic        wr_a_tag;
	logic        wr_b_ch1;
	logic        wr_b_ch2;
	logic        wr_b_tag;
	logic        wr_c_ch1;
	logic        wr_c_ch2;
	logic        wr_c_tag;

	// ------------------------------------------------------------------
	// Write decode
	// ------------------------------------------------------------------
	assign wr_a_ch1 = req.wr && (req.addr == `CAL_ADDR_A_CH1);
	assign wr_a_ch2 = req.wr && (req.addr == `CAL_ADDR_A_CH2);
	assign wr_a_tag = req.wr && (req.addr == `CAL_ADDR_A_TAG);
	assign wr_b_ch1 = req.wr && (req.addr == `CAL_ADDR_B_CH1);
	assign wr_b_ch2 = req.wr && (req.addr == `CAL_ADDR_B_CH2);
	assign wr_b_tag = req.wr && (req.addr == `CAL_ADDR_B_TAG);
	assign wr_c_ch1 = req.wr && (req.addr == `CAL_ADDR_C_CH1);
	assign wr_c_ch2 = req.wr && (req.addr == `CAL_ADDR_C_CH2);
	assign wr_c_tag = req.wr && (req.addr == `CAL_ADDR_C_TAG);

	// ------------------------------------------------------------------
	// Set A registers
	// ------------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			set_a_r.en  <= `CAL_EN_RST;
			set_a_r.ch1 <= `CAL_TRIM_RST;
		end else if (wr_a_ch1) begin
			// Bit 6 is reserved and simply not stored
			set_a_r.en  <= req.wdata[`CAL_EN_BIT];
			set_a_r.ch1 <= req.wdata[`CAL_TRIM_MSB:`CAL_TRIM_LSB];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			set_a_r.ch2 <= `CAL_TRIM_RST;
		end else if (wr_a_ch2) begin
			set_a_r.ch2 <= req.wdata[`CAL_TRIM_MSB:`CAL_TRIM_LSB];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			set_a_r.tag <= `CAL_TAG_RST;
		end else if (wr_a_tag) begin
			set_a_r.tag <= req.wdata;
		end
	end

	// ------------------------------------------------------------------
	// Set B registers
	// ------------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			set_b_r.en  <= `CAL_EN_RST;
			set_b_r.ch1 <= `CAL_TRIM_RST;
		end else if (wr_b_ch1) begin
			set_b_r.en  <= req.wdata[`CAL_EN_BIT];
			set_b_r.ch1 <= req.wdata[`CAL_TRIM_MSB:`CAL_TRIM_LSB];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			set_b_r.ch2 <= `CAL_TRIM_RST;
		end else if (wr_b_ch2) begin
			set_b_r.ch2 <= req.wdata[`CAL_TRIM_MSB:`CAL_TRIM_LSB];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			set_b_r.tag <= `CAL_TAG_RST;
		end else if (wr_b_tag) begin
			set_b_r.tag <= req.wdata;
		end
	end

	// ------------------------------------------------------------------
	// Set C registers
	// ------------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			set_c_r.en  <= `CAL_EN_RST;
			set_c_r.ch1 <= `CAL_TRIM_RST;
		end else if (wr_c_ch1) begin
			set_c_r.en  <= req.wdata[`CAL_EN_BIT];
			set_c_r.ch1 <= req.wdata[`CAL_TRIM_MSB:`CAL_TRIM_LSB];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			set_c_r.ch2 <= `CAL_TRIM_RST;
		end else if (wr_c_ch2) begin
			set_c_r.ch2 <= req.wdata[`CAL_TRIM_MSB:`CAL_TRIM_LSB];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			set_c_r.tag <= `CAL_TAG_RST;
		end else if (wr_c_tag) begin
			set_c_r.tag <= req.wdata;
		end
	end

	// ------------------------------------------------------------------
	// Register images as software sees them
	// ------------------------------------------------------------------
	// The checksum is taken over these images, so reserved bits count as zero
	logic [7:0] img_a_ch1;
	logic [7:0] img_a_ch2;
	logic [7:0] img_b_ch1;
	logic [7:0] img_b_ch2;
	logic [7:0] img_c_ch1;
	logic [7:0] img_c_ch2;

	assign img_a_ch1 = {set_a_r.en, 1'b0, set_a_r.ch1};
	assign img_a_ch2 = {2'b00, set_a_r.ch2};
	assign img_b_ch1 = {set_b_r.en, 1'b0, set_b_r.ch1};
	assign img_b_ch2 = {2'b00, set_b_r.ch2};
	assign img_c_ch1 = {set_c_r.en, 1'b0, set_c_r.ch1};
	assign img_c_ch2 = {2'b00, set_c_r.ch2};

	// ------------------------------------------------------------------
	// Checksum per set
	// ------------------------------------------------------------------
	logic [7:0] crc_a;
	logic [7:0] crc_b;
	logic [7:0] crc_c;
	logic       ok_a;
	logic       ok_b;
	logic       ok_c;

	cal_tag_crc u_crc_a (
		.byte0 (img_a_ch1),
		.byte1 (img_a_ch2),
		.crc   (crc_a)
	);

	cal_tag_crc u_crc_b (
		.byte0 (img_b_ch1),
		.byte1 (img_b_ch2),
		.crc   (crc_b)
	);

	cal_tag_crc u_crc_c (
		.byte0 (img_c_ch1),
		.byte1 (img_c_ch2),
		.crc   (crc_c)
	);

	// A tag only counts while its set is enabled
	assign ok_a = set_a_r.en && (crc_a == set_a_r.tag);
	assign ok_b = set_b_r.en && (crc_b == set_b_r.tag);
	assign ok_c = set_c_r.en && (crc_c == set_c_r.tag);

	// ------------------------------------------------------------------
	// Priority selection
	// ------------------------------------------------------------------
	cal_sel_t   sel_nxt;
	logic       mismatch_nxt;
	logic [5:0] trim1_nxt;
	logic [5:0] trim2_nxt;

	always_comb begin
		if (set_c_r.en) begin
			sel_nxt = SEL_C;
		end else if (set_b_r.en) begin
			sel_nxt = SEL_B;
		end else if (set_a_r.en) begin
			sel_nxt = SEL_A;
		end else begin
			sel_nxt = SEL_NONE;
		end
	end

	// A refused set does not fall back to a lower one: a bad tag means the
	// part was programmed wrongly, and unity gain is the safer outcome
	always_comb begin
		case (sel_nxt)
			SEL_A: begin
				mismatch_nxt = !ok_a;
				trim1_nxt    = set_a_r.ch1;
				trim2_nxt    = set_a_r.ch2;
			end
			SEL_B: begin
				mismatch_nxt = !ok_b;
				trim1_nxt    = set_b_r.ch1;
				trim2_nxt    = set_b_r.ch2;
			end
			SEL_C: begin
				mismatch_nxt = !ok_c;
				trim1_nxt    = set_c_r.ch1;
				trim2_nxt    = set_c_r.ch2;
			end
			default: begin
				mismatch_nxt = 1'b0;
				trim1_nxt    = `CAL_TRIM_RST;
				trim2_nxt    = `CAL_TRIM_RST;
			end
		endcase
	end

	// ------------------------------------------------------------------
	// Gain arithmetic
	// ------------------------------------------------------------------
	logic signed [17:0] step_s;
	logic signed [17:0] trim1_s;
	logic signed [17:0] trim2_s;
	logic signed [17:0] prod1;
	logic signed [17:0] prod2;
	gain_pair_t         gain_nxt;

	assign step_s  = $signed(`CAL_GAIN_STEP);
	assign trim1_s = $signed({{12{trim1_nxt[5]}}, trim1_nxt});
	assign trim2_s = $signed({{12{trim2_nxt[5]}}, trim2_nxt});
	// Largest product is 32 * 320, well inside 18 bits
	assign prod1   = 18'(trim1_s * step_s);
	assign prod2   = 18'(trim2_s * step_s);

	always_comb begin
		if (sel_nxt == SEL_NONE || mismatch_nxt) begin
			gain_nxt.ch1 = `CAL_GAIN_UNITY;
			gain_nxt.ch2 = `CAL_GAIN_UNITY;
		end else begin
			gain_nxt.ch1 = 18'($signed(`CAL_GAIN_UNITY) + prod1);
			gain_nxt.ch2 = 18'($signed(`CAL_GAIN_UNITY) + prod2);
		end
	end

	// ------------------------------------------------------------------
	// Result registers
	// ------------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			gain_r.ch1 <= `CAL_GAIN_UNITY;
			gain_r.ch2 <= `CAL_GAIN_UNITY;
		end else begin
			gain_r <= gain_nxt;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			sel_r      <= SEL_NONE;
			mismatch_r <= 1'b0;
		end else begin
			sel_r      <= sel_nxt;
			mismatch_r <= mismatch_nxt;
		end
	end

	// ------------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------------
	logic [7:0] status_img;
	logic [7:0] rdata_nxt;

	always_comb begin
		status_img = 8'h00;
		status_img[`CAL_ST_SEL_LSB +: 2]   = sel_r;
		status_img[`CAL_ST_MISMATCH_BIT]   = mismatch_r;
		status_img[`CAL_ST_OK_LSB +: 3]    = {ok_c, ok_b, ok_a};
	end

	always_comb begin
		case (req.addr)
			`CAL_ADDR_STATUS: rdata_nxt = status_img;
			`CAL_ADDR_A_CH1:  rdata_nxt = img_a_ch1;
			`CAL_ADDR_A_CH2:  rdata_nxt = img_a_ch2;
			`CAL_ADDR_A_TAG:  rdata_nxt = set_a_r.tag;
			`CAL_ADDR_B_CH1:  rdata_nxt = img_b_ch1;
			`CAL_ADDR_B_CH2:  rdata_nxt = img_b_ch2;
			`CAL_ADDR_B_TAG:  rdata_nxt = set_b_r.tag;
			`CAL_ADDR_C_CH1:  rdata_nxt = img_c_ch1;
			`CAL_ADDR_C_CH2:  rdata_nxt = img_c_ch2;
			`CAL_ADDR_C_TAG:  rdata_nxt = set_c_r.tag;
			// Addresses outside this bank answer zero
			default:          rdata_nxt = 8'h00;
		endcase
	end

	// Read data is valid only in the cycle after the strobe, zero otherwise
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			rdata_r <= 8'h00;
		end else if (req.rd) begin
			rdata_r <= rdata_nxt;
		end else begin
			rdata_r <= 8'h00;
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign rdata        = rdata_r;
	assign gain         = gain_r;
	assign active_set   = sel_r;
	assign tag_mismatch = mismatch_r;

endmodule

// ### core/cal_tag_consts.svh
// Offsets, field positions, reset values and fixed-point constants of the
// colour calibration tag bank. Included by the package users; no logic here.
`ifndef CAL_TAG_CONSTS_SVH
`define CAL_TAG_CONSTS_SVH

// ----------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------
`define CAL_ADDR_STATUS      7'h76
`define CAL_ADDR_A_CH1       7'h77
`define CAL_ADDR_A_CH2       7'h78
`define CAL_ADDR_A_TAG       7'h79
`define CAL_ADDR_B_CH1       7'h7a
`define CAL_ADDR_B_CH2       7'h7b
`define CAL_ADDR_B_TAG       7'h7c
`define CAL_ADDR_C_CH1       7'h7d
`define CAL_ADDR_C_CH2       7'h7e
`define CAL_ADDR_C_TAG       7'h7f

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CAL_EN_BIT           7
`define CAL_TRIM_MSB         5
`define CAL_TRIM_LSB         0
`define CAL_ST_SEL_LSB       0
`define CAL_ST_MISMATCH_BIT  2
`define CAL_ST_OK_LSB        3

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define CAL_TRIM_RST         6'h00
`define CAL_TAG_RST          8'h00
`define CAL_EN_RST           1'b0

// ----------------------------------------------------------------------
// Checksum and gain arithmetic
// ----------------------------------------------------------------------
`define CAL_CRC_POLY         8'h07
`define CAL_CRC_INIT         8'h00
// Gain is unsigned Q2.16; 0.00488 * 65536 = 319.8, taken as 320
`define CAL_GAIN_UNITY       18'h10000
`define CAL_GAIN_STEP        18'h00140

`endif

// ### core/cal_tag_pkg.sv
// Types shared by the calibration tag bank, its checker and its bench.
// Assumes cal_tag_consts.svh for the numeric constants.
package cal_tag_pkg;

	// Active set, Gray coded along none -> A -> B -> C
	typedef enum logic [1:0] {
		SEL_NONE = 2'b00,
		SEL_A    = 2'b01,
		SEL_B    = 2'b11,
		SEL_C    = 2'b10
	} cal_sel_t;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [6:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic       en;
		logic [5:0] ch1;
		logic [5:0] ch2;
		logic [7:0] tag;
	} cal_set_t;

	typedef struct packed {
		logic [17:0] ch1;
		logic [17:0] ch2;
	} gain_pair_t;

endpackage

// ### core/cal_tag_crc.sv
// Checksum over the two calibration bytes of one set, MSB first.
// Purely combinational; polynomial and seed are parameters.
`timescale 1ns/1ns
`include "cal_tag_consts.svh"

module cal_tag_crc #(
	parameter logic [7:0] POLY = `CAL_CRC_POLY,
	parameter logic [7:0] INIT = `CAL_CRC_INIT
) (
	input  wire logic [7:0] byte0,
	input  wire logic [7:0] byte1,
	output logic      [7:0] crc
);
	logic [15:0] msg;
	assign msg = {byte0, byte1};

	always_comb begin
		logic [7:0] c;
		c = INIT;
		for (int i = 15; i >= 0; i--) begin
			if (c[7] ^ msg[i]) begin
				c = {c[6:0], 1'b0} ^ POLY;
			end else begin
				c = {c[6:0], 1'b0};
			end
		end
		crc = c;
	end
endmodule

// ### verification/cal_tag_bank_monitor.sv
// Port-level checker for the calibration tag bank.
// Assumes it is bound to cal_tag_bank and sees its ports unchanged.
`timescale 1ns/1ns
`include "cal_tag_consts.svh"

module cal_tag_bank_monitor (
	input wire logic                    sys_clk,
	input wire logic                    rst_n,
	input wire cal_tag_pkg::reg_req_t   req,
	input wire logic              [7:0] rdata,
	input wire cal_tag_pkg::gain_pair_t gain,
	input wire cal_tag_pkg::cal_sel_t   active_set,
	input wire logic                    tag_mismatch
);
	import cal_tag_pkg::*;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	// ------------------------------------------------------------
	// Read port
	// ------------------------------------------------------------
	a_rdata_idle_zero: assert property (!req.rd |=> rdata == 8'h00)
		else $error("read data not zero outside a read");
	a_unmapped_read: assert property (req.rd && req.addr < 7'h76 |=> rdata == 8'h00)
		else $error("unmapped read not zero");
	a_ch1_rsvd_zero: assert property (req.rd && req.addr inside {7'h77, 7'h7a, 7'h7d}
		|=> rdata[6] == 1'b0)
		else $error("channel-1 reserved bit read back set");
	a_ch2_rsvd_zero: assert property (req.rd && req.addr inside {7'h78, 7'h7b, 7'h7e}
		|=> rdata[7:6] == 2'b00)
		else $error("channel-2 reserved bits read back set");
	a_status_image: assert property (req.rd && req.addr == 7'h76
		|=> rdata[2:0] == {$past(tag_mismatch), $past(active_set)} && rdata[7:6] == 2'b00)
		else $error("status does not mirror selection");
	// ------------------------------------------------------------
	// Gain outputs
	// ------------------------------------------------------------
	// Unity while nothing is selected or the selection is refused
	a_none_unity: assert property (active_set == SEL_NONE
		|-> gain == {`CAL_GAIN_UNITY, `CAL_GAIN_UNITY} && !tag_mismatch)
		else $error("gains not unity with no set");
	a_mismatch_unity: assert property (tag_mismatch
		|-> gain == {`CAL_GAIN_UNITY, `CAL_GAIN_UNITY} && active_set != SEL_NONE)
		else $error("refused set still drives gains");
	a_gain_range: assert property (active_set != SEL_NONE && !tag_mismatch
		|-> gain.ch1 >= 18'd55296 && gain.ch1 <= 18'd75456
		&& gain.ch2 >= 18'd55296 && gain.ch2 <= 18'd75456)
		else $error("gain outside the trim span");
	a_gain_hold: assert property (!req.wr ##1 !req.wr
		|=> $stable(gain) && $stable(active_set) && $stable(tag_mismatch))
		else $error("outputs moved without a write");
endmodule

bind cal_tag_bank cal_tag_bank_monitor i_mon (
	.sys_clk     (sys_clk),
	.rst_n       (rst_n),
	.req         (req),
	.rdata       (rdata),
	.gain        (gain),
	.active_set  (active_set),
	.tag_mismatch(tag_mismatch)
);

// ### verification/cal_tag_bank_tb.sv
// Self-checking bench for the calibration tag bank.
// Assumes the design package, constants header and the bound checker.
`timescale 1ns/1ns
`include "cal_tag_consts.svh"

module cal_tag_bank_tb;
	import cal_tag_pkg::*;
	logic        sys_clk;
	logic        rst_n;
	reg_req_t    req;
	logic  [7:0] rdata;
	gain_pair_t  gain;
	cal_sel_t    active_set;
	logic        tag_mismatch;
	logic  [2:0] en;
	logic  [5:0] t1 [3];
	logic  [5:0] t2 [3];
	logic  [7:0] tg [3];
	int          fail_count = 0;
	int          compares = 0;

	cal_tag_bank i_dut (
		.sys_clk     (sys_clk),
		.rst_n       (rst_n),
		.req         (req),
		.rdata       (rdata),
		.gain        (gain),
		.active_set  (active_set),
		.tag_mismatch(tag_mismatch)
	);

	// ------------------------------------------------------------
	// Expectations
	// ------------------------------------------------------------
	function automatic logic [7:0] crc8(input logic [7:0] a, input logic [7:0] b);
		logic [15:0] d;
		logic  [7:0] c;
		d = {a, b};
		c = `CAL_CRC_INIT;
		for (int i = 15; i >= 0; i--) begin
			c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? `CAL_CRC_POLY : 8'h00);
		end
		return c;
	endfunction

	function automatic logic ok(input int i);
		return en[i] && crc8({en[i], 1'b0, t1[i]}, {2'b00, t2[i]}) == tg[i];
	endfunction

	function automatic logic [17:0] g(input logic [5:0] t);
		int v;
		v = 65536 + $signed(t) * 320;
		return v[17:0];
	endfunction

	// ------------------------------------------------------------
	// Bus tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic put(input logic w, input logic r, input logic [6:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		req <= '{wr: w, rd: r, addr: a, wdata: d};
	endtask

	task automatic idle;
		put(1'b0, 1'b0, 7'h00, 8'h00);
	endtask

	task automatic rd(input logic [6:0] a, input logic [7:0] e);
		put(1'b0, 1'b1, a, 8'h00);
		idle;
		#1;
		chk(rdata, e);
	endtask

	// Outputs settle two edges after the last write
	task automatic check_out;
		int         s;
		logic [2:0] okv;
		logic       mm;
		cal_sel_t   es;
		s = en[2] ? 2 : en[1] ? 1 : en[0] ? 0 : -1;
		for (int i = 0; i < 3; i++) okv[i] = ok(i);
		es = s == 2 ? SEL_C : s == 1 ? SEL_B : s == 0 ? SEL_A : SEL_NONE;
		mm = s >= 0 && !okv[s];
		idle;
		idle;
		#1;
		chk(active_set, es);
		chk(tag_mismatch, mm);
		chk(gain.ch1, (s < 0 || mm) ? `CAL_GAIN_UNITY : g(t1[s]));
		chk(gain.ch2, (s < 0 || mm) ? `CAL_GAIN_UNITY : g(t2[s]));
		rd(`CAL_ADDR_STATUS, {2'b00, okv, mm, es});
	endtask

	// ------------------------------------------------------------
	// Run
	// ------------------------------------------------------------
	task automatic give_verdict;
		$display("compares=%0d fail_count=%0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end

	initial begin
		#1000000;
		fail_count++;
		give_verdict;
	end

	initial begin
		logic [6:0] a;
		rst_n <= 1'b0;
		req <= '0;
		void'($urandom(61));
		repeat (3) @(posedge sys_clk);
		rst_n <= 1'b1;
		for (int i = 'h76; i < 'h80; i++) rd(7'(i), 8'h00);
		chk(gain, {`CAL_GAIN_UNITY, `CAL_GAIN_UNITY});
		put(1'b1, 1'b0, 7'h10, 8'hff);
		put(1'b1, 1'b0, `CAL_ADDR_STATUS, 8'hff);
		rd(7'h10, 8'h00);
		rd(`CAL_ADDR_STATUS, 8'h00);
		$display("reset and unmapped test done");
		// Disabled sets get a wrong tag on purpose; it must stay unseen
		for (int n = 0; n < 30; n++) begin
			en = n < 8 ? 3'(n) : 3'($urandom);
			for (int i = 0; i < 3; i++) begin
				t1[i] = n == 7 ? 6'h20 : n == 6 ? 6'h1f : 6'($urandom);
				t2[i] = n == 7 ? 6'h1f : n == 6 ? 6'h20 : 6'($urandom);
				tg[i] = crc8({en[i], 1'b0, t1[i]}, {2'b00, t2[i]})
					^ {7'h00, !en[i] || (n >= 8 && $urandom % 4 == 0)};
				a = 7'(`CAL_ADDR_A_CH1 + 3 * i);
				put(1'b1, 1'b0, a, {en[i], 1'($urandom), t1[i]});
				put(1'b1, 1'b0, a + 7'h01, {2'($urandom), t2[i]});
				put(1'b1, 1'b0, a + 7'h02, tg[i]);
				rd(a, {en[i], 1'b0, t1[i]});
				rd(a + 7'h01, {2'b00, t2[i]});
				rd(a + 7'h02, tg[i]);
			end
			check_out;
			$display("selection test %0d done", n);
		end
		give_verdict;
	end
endmodule
